/* File: core/dma_size_ptr_cfg.svh */
`ifndef DMA_SIZE_PTR_CFG_SVH
`define DMA_SIZE_PTR_CFG_SVH

// Register word offsets, byte addresses on the plain register port
`define DSP_OFS_DEST_SIZE   8'h00
`define DSP_OFS_SRC_PTR     8'h04
`define DSP_OFS_DEST_PTR    8'h08
`define DSP_OFS_SRC_SIZE    8'h0c
`define DSP_OFS_CTRL        8'h10
`define DSP_OFS_IRQ_STATUS  8'h14
`define DSP_OFS_IRQ_MASK    8'h18

// Field positions
`define DSP_SIZE_MSB        15
`define DSP_CTRL_PATTERN    0
`define DSP_IRQ_MSB         4

// Reset values
`define DSP_RST_SIZE        16'h0000
`define DSP_RST_PTR         16'h0000
`define DSP_RST_IRQ         5'h00

// Block length that an all-zero size field stands for
`define DSP_FULL_SPAN       17'h10000

`endif

/* File: core/dma_size_ptr_pkg.sv */
`include "dma_size_ptr_cfg.svh"

package dma_size_ptr_pkg;

  typedef logic [`DSP_SIZE_MSB:0]   count16_t;
  typedef logic [`DSP_SIZE_MSB+1:0] span_t;

  // Sticky event bits, status and mask share this layout
  typedef struct packed {
    logic src_done_flag;
    logic src_half_flag;
    logic dest_done_flag;
    logic dest_half_flag;
    logic block_complete_flag;
  } irq_bits_t;

  // One register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // Byte movement and match events from the channel engine
  typedef struct packed {
    logic src_byte;
    logic dst_byte;
    logic pattern_match;
  } xfer_evt_t;

  // Whole state of the block
  typedef struct packed {
    count16_t    dest_size_field;
    count16_t    source_size_field;
    count16_t    source_progress_pointer;
    count16_t    dest_progress_pointer;
    logic        pattern_mode;
    irq_bits_t   irq_status;
    irq_bits_t   irq_mask;
    logic [31:0] rdata;
  } state_t;

endpackage

/* File: core/dma_channel_size_pointer_regs.sv */
// Summary of operation
// - A 16-bit writable destination size sits in bits 15..0 and resets to zero.
// - A nonzero destination size N makes the destination block exactly N bytes long.
// - A destination size of zero means a 65,536-byte destination block.
// - Bits 31..16 of the size and pointer registers ignore writes and read zero.
// - The source pointer is a 16-bit read-only field that resets to zero.
// - The source pointer holds the index of the current byte of the source block.
// - In pattern-detect mode a pattern match clears the source pointer to zero.
// - The destination pointer is a 16-bit read-only field that resets to zero.
// - The destination pointer holds the index of the current byte of the destination block.
// - Destination done is flagged when the destination pointer reaches the destination size.
// - Destination half is flagged when the destination pointer reaches half that size.
// - Block complete is flagged when the larger block is moved, or on a pattern match in pattern-detect mode.
// - A source size N means N bytes, and zero means 65,536 bytes.

`include "dma_size_ptr_cfg.svh"

module dma_channel_size_pointer_regs (
  input  wire logic                       i_clk,
  input  wire logic                       i_sys_rst,
  input  wire dma_size_ptr_pkg::reg_req_t  i_req,
  input  wire dma_size_ptr_pkg::xfer_evt_t i_evt,
  output logic [31:0]                     o_rdata,
  output logic                            o_irq,
  output dma_size_ptr_pkg::count16_t      o_source_progress_pointer,
  output dma_size_ptr_pkg::count16_t      o_dest_progress_pointer
);

  ////////////////////////////////////////////////////////////////////////////
  // State and its next value
  ////////////////////////////////////////////////////////////////////////////

  dma_size_ptr_pkg::state_t    state_reg;
  dma_size_ptr_pkg::state_t    state_next;

  // Block lengths in bytes, one bit wider than the size fields
  dma_size_ptr_pkg::span_t     dest_span;
  dma_size_ptr_pkg::span_t     src_span;

  // Pointer values once the current byte is counted
  dma_size_ptr_pkg::count16_t  src_step_next;
  dma_size_ptr_pkg::count16_t  dest_step_next;

  // Sticky status after this cycle and the level request
  dma_size_ptr_pkg::irq_bits_t status_next;
  logic                        irq_pending;

  // Per-cycle events
  logic                        src_wrap;
  logic                        dest_wrap;
  logic                        src_half_hit;
  logic                        dest_half_hit;
  logic                        pattern_clear;
  logic                        block_done_hit;
  dma_size_ptr_pkg::irq_bits_t new_events;
  dma_size_ptr_pkg::irq_bits_t clear_bits;

  ////////////////////////////////////////////////////////////////////////////
  // Source side
  ////////////////////////////////////////////////////////////////////////////

  // A match in pattern-detect mode restarts the source count
  assign pattern_clear = state_reg.pattern_mode & i_evt.pattern_match;

  // Source size decode, byte count and marks; a match swallows the byte
  span_pointer_step #(
    .WIDTH (16)
  ) src_side (
    .i_size         (state_reg.source_size_field),
    .i_pointer      (state_reg.source_progress_pointer),
    .i_byte         (i_evt.src_byte),
    .i_hold         (pattern_clear),
    .o_span         (src_span),
    .o_wrap         (src_wrap),
    .o_half_hit     (src_half_hit),
    .o_pointer_next (src_step_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Destination side
  ////////////////////////////////////////////////////////////////////////////

  // Destination size decode, byte count and marks; no event holds a byte here
  span_pointer_step #(
    .WIDTH (16)
  ) dest_side (
    .i_size         (state_reg.dest_size_field),
    .i_pointer      (state_reg.dest_progress_pointer),
    .i_byte         (i_evt.dst_byte),
    .i_hold         (1'b0),
    .o_span         (dest_span),
    .o_wrap         (dest_wrap),
    .o_half_hit     (dest_half_hit),
    .o_pointer_next (dest_step_next)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Block completion
  ////////////////////////////////////////////////////////////////////////////

  // Larger side finishing closes the block; destination decides a tie
  assign block_done_hit = (src_wrap & (src_span > dest_span)) |
                          (dest_wrap & (dest_span >= src_span)) |
                          pattern_clear;

  ////////////////////////////////////////////////////////////////////////////
  // Event collection
  ////////////////////////////////////////////////////////////////////////////

  // Events gathered in status layout
  always_comb begin
    new_events                     = '0;
    new_events.src_done_flag       = src_wrap;
    new_events.src_half_flag       = src_half_hit;
    new_events.dest_done_flag      = dest_wrap;
    new_events.dest_half_flag      = dest_half_hit;
    new_events.block_complete_flag = block_done_hit;
  end

  // Write-one-to-clear bits of a status write
  assign clear_bits = (i_req.wr && (i_req.addr == `DSP_OFS_IRQ_STATUS)) ?
                      i_req.wdata[`DSP_IRQ_MSB:0] :
                      '0;

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  ////////////////////////////////////////////////////////////////////////////

  always_comb begin
    state_next = state_reg;

    // Source pointer: a match clears it, otherwise the stepped value
    if (pattern_clear) begin
      state_next.source_progress_pointer = `DSP_RST_PTR;
    end else begin
      state_next.source_progress_pointer = src_step_next;
    end

    // Destination pointer: stepped value, wrapping at the block end
    state_next.dest_progress_pointer = dest_step_next;

    // Register writes; pointers have no write path
    if (i_req.wr) begin
      unique case (i_req.addr)
        `DSP_OFS_DEST_SIZE: begin
          state_next.dest_size_field = i_req.wdata[`DSP_SIZE_MSB:0];
        end
        `DSP_OFS_SRC_SIZE: begin
          state_next.source_size_field = i_req.wdata[`DSP_SIZE_MSB:0];
        end
        `DSP_OFS_CTRL: begin
          state_next.pattern_mode = i_req.wdata[`DSP_CTRL_PATTERN];
        end
        `DSP_OFS_IRQ_MASK: begin
          state_next.irq_mask = i_req.wdata[`DSP_IRQ_MSB:0];
        end
        default: begin
          // Pointers and unmapped words keep their value; status writes act through clear_bits
        end
      endcase
    end

    // Sticky flags: a new event wins over a clear in the same cycle
    state_next.irq_status = status_next;

    // Read data stands for one cycle after the read strobe
    state_next.rdata = 32'h0000_0000;
    if (i_req.rd) begin
      unique case (i_req.addr)
        `DSP_OFS_DEST_SIZE: begin
          state_next.rdata = {16'h0000, state_reg.dest_size_field};
        end
        `DSP_OFS_SRC_PTR: begin
          state_next.rdata = {16'h0000, state_reg.source_progress_pointer};
        end
        `DSP_OFS_DEST_PTR: begin
          state_next.rdata = {16'h0000, state_reg.dest_progress_pointer};
        end
        `DSP_OFS_SRC_SIZE: begin
          state_next.rdata = {16'h0000, state_reg.source_size_field};
        end
        `DSP_OFS_CTRL: begin
          state_next.rdata = {31'h0000_0000, state_reg.pattern_mode};
        end
        `DSP_OFS_IRQ_STATUS: begin
          state_next.rdata = {27'h000_0000, state_reg.irq_status};
        end
        `DSP_OFS_IRQ_MASK: begin
          state_next.rdata = {27'h000_0000, state_reg.irq_mask};
        end
        default: begin
          state_next.rdata = 32'h0000_0000;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  ////////////////////////////////////////////////////////////////////////////

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_reg.dest_size_field         <= `DSP_RST_SIZE;
      state_reg.source_size_field       <= `DSP_RST_SIZE;
      state_reg.source_progress_pointer <= `DSP_RST_PTR;
      state_reg.dest_progress_pointer   <= `DSP_RST_PTR;
      state_reg.pattern_mode            <= 1'b0;
      state_reg.irq_status              <= `DSP_RST_IRQ;
      state_reg.irq_mask                <= `DSP_RST_IRQ;
      state_reg.rdata                   <= 32'h0000_0000;
    end else begin
      state_reg <= state_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs
  ////////////////////////////////////////////////////////////////////////////

  // Data outputs straight from flops
  assign o_rdata                   = state_reg.rdata;
  assign o_source_progress_pointer = state_reg.source_progress_pointer;
  assign o_dest_progress_pointer   = state_reg.dest_progress_pointer;

  // Sticky flags and the level request they raise
  sticky_event_bits #(
    .WIDTH (5)
  ) irq_bits (
    .i_status      (state_reg.irq_status),
    .i_set         (new_events),
    .i_clear       (clear_bits),
    .i_mask        (state_reg.irq_mask),
    .o_status_next (status_next),
    .o_pending     (irq_pending)
  );

  // Level interrupt while any unmasked flag is set
  assign o_irq = irq_pending;

endmodule

////////////////////////////////////////////////////////////////////////////
// One channel side: size decode, byte counting and block marks
////////////////////////////////////////////////////////////////////////////

module span_pointer_step #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic [WIDTH-1:0] i_size,
  input  wire logic [WIDTH-1:0] i_pointer,
  input  wire logic             i_byte,
  input  wire logic             i_hold,
  output logic [WIDTH:0]        o_span,
  output logic                  o_wrap,
  output logic                  o_half_hit,
  output logic [WIDTH-1:0]      o_pointer_next
);

  // Midpoint of the block and the count including the current byte
  logic [WIDTH:0] half_mark;
  logic [WIDTH:0] after;
  logic           counted;

  ////////////////////////////////////////////////////////////////////////////
  // Size decoding
  ////////////////////////////////////////////////////////////////////////////

  // Zero size stands for the full span, one bit beyond the field
  assign o_span = (i_size == `DSP_RST_SIZE) ?
                  `DSP_FULL_SPAN :
                  {1'b0, i_size};

  // Midpoint; a one-byte block has none that a pointer can reach
  assign half_mark = o_span >> 1;

  ////////////////////////////////////////////////////////////////////////////
  // Byte counting
  ////////////////////////////////////////////////////////////////////////////

  // A held byte neither counts nor marks anything
  assign counted = i_byte & ~i_hold;

  // Bytes moved including the current one
  assign after = {1'b0, i_pointer} + {{WIDTH{1'b0}}, 1'b1};

  ////////////////////////////////////////////////////////////////////////////
  // Block marks
  ////////////////////////////////////////////////////////////////////////////

  // End of block reached by this byte
  assign o_wrap = counted & (after == o_span);

  // Midpoint reached by this byte
  assign o_half_hit = counted & (after == half_mark);

  ////////////////////////////////////////////////////////////////////////////
  // Next pointer
  ////////////////////////////////////////////////////////////////////////////

  // Pointer after this byte; a finished block restarts at byte zero
  always_comb begin
    o_pointer_next = i_pointer;
    if (counted) begin
      if (o_wrap) begin
        o_pointer_next = `DSP_RST_PTR;
      end else begin
        o_pointer_next = after[WIDTH-1:0];
      end
    end
  end

endmodule

////////////////////////////////////////////////////////////////////////////
// Sticky event bits: set by hardware, cleared by writing ones
////////////////////////////////////////////////////////////////////////////

module sticky_event_bits #(
  parameter int unsigned WIDTH = 5
) (
  input  wire logic [WIDTH-1:0] i_status,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic [WIDTH-1:0] i_clear,
  input  wire logic [WIDTH-1:0] i_mask,
  output logic [WIDTH-1:0]      o_status_next,
  output logic                  o_pending
);

  ////////////////////////////////////////////////////////////////////////////
  // Next status
  ////////////////////////////////////////////////////////////////////////////

  // A new event wins over a clear of the same bit in the same cycle
  assign o_status_next = (i_status & ~i_clear) | i_set;

  ////////////////////////////////////////////////////////////////////////////
  // Pending request
  ////////////////////////////////////////////////////////////////////////////

  // Any set bit that the mask lets through
  assign o_pending = |(i_status & i_mask);

endmodule

/* File: tb/dma_size_ptr_asserts.sv */
module dma_size_ptr_asserts (
  input wire logic                        i_clk,
  input wire logic                        i_sys_rst,
  input wire dma_size_ptr_pkg::reg_req_t  i_req,
  input wire dma_size_ptr_pkg::xfer_evt_t i_evt,
  input wire logic [31:0]                 o_rdata,
  input wire logic                        o_irq,
  input wire dma_size_ptr_pkg::count16_t  o_source_progress_pointer,
  input wire dma_size_ptr_pkg::count16_t  o_dest_progress_pointer
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // Read port and pointer stepping
  chk_rdata_idle: assert property (!$past(i_req.rd) |-> o_rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  chk_size_readback: assert property ($past(i_req.wr, 3) && $past(i_req.addr, 3) == 8'h00 &&
    !$past(i_req.wr, 2) && $past(i_req.rd) && $past(i_req.addr) == 8'h00
    |-> o_rdata == {16'h0, $past(i_req.wdata[15:0], 3)}) else $error("size readback wrong");
  chk_src_read: assert property ($past(i_req.rd) && $past(i_req.addr) == 8'h04
    |-> o_rdata == {16'h0, $past(o_source_progress_pointer)}) else $error("src read wrong");
  chk_dst_read: assert property ($past(i_req.rd) && $past(i_req.addr) == 8'h08
    |-> o_rdata == {16'h0, $past(o_dest_progress_pointer)}) else $error("dest read wrong");
  chk_src_step: assert property (i_evt.src_byte && !i_evt.pattern_match |=>
    o_source_progress_pointer == $past(o_source_progress_pointer) + 16'h1 ||
    o_source_progress_pointer == 16'h0) else $error("src pointer step wrong");
  chk_src_hold: assert property (!i_evt.src_byte && !i_evt.pattern_match |=>
    $stable(o_source_progress_pointer)) else $error("src pointer moved without byte");
  chk_dst_step: assert property (i_evt.dst_byte |=>
    o_dest_progress_pointer == $past(o_dest_progress_pointer) + 16'h1 ||
    o_dest_progress_pointer == 16'h0) else $error("dest pointer step wrong");
  chk_dst_hold: assert property (!i_evt.dst_byte |=> $stable(o_dest_progress_pointer))
    else $error("dest pointer moved without byte");
endmodule

bind dma_channel_size_pointer_regs dma_size_ptr_asserts u_chk (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_req(i_req), .i_evt(i_evt), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_source_progress_pointer(o_source_progress_pointer),
  .o_dest_progress_pointer(o_dest_progress_pointer));

/* File: tb/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        clk = 1'b0;
  logic                        rst = 1'b1;
  dma_size_ptr_pkg::reg_req_t  req = '0;
  dma_size_ptr_pkg::xfer_evt_t evt = '0;
  logic [31:0]                 rdata;
  logic                        irq;
  dma_size_ptr_pkg::count16_t  sptr;
  dma_size_ptr_pkg::count16_t  dptr;
  int                          num_errors = 0;
  int                          comparisons = 0;
  int                          cycles = 0;
  ////////////////////////////////////////////////////////////////////////////////
  // Clock, device and hang guard
  always #12.5 clk = ~clk;
  dma_channel_size_pointer_regs dut (.i_clk(clk), .i_sys_rst(rst), .i_req(req), .i_evt(evt),
    .o_rdata(rdata), .o_irq(irq), .o_source_progress_pointer(sptr),
    .o_dest_progress_pointer(dptr));
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 80000) begin
      num_errors++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Compare, bus and event helpers
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
    #1;
  endtask
  task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1;
    chk(name, exp, rdata);
  endtask
  task automatic pulse(input logic [2:0] e, input int n);
    repeat (n) begin
      @(posedge clk);
      evt <= e;
    end
    @(posedge clk);
    evt <= '0;
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic t_regs();
    rd_chk("dest_size", 8'h00, 32'h0);
    rd_chk("src_ptr", 8'h04, 32'h0);
    rd_chk("dest_ptr", 8'h08, 32'h0);
    wr(8'h00, 32'hffff_1234);
    rd_chk("dest_size", 8'h00, 32'h0000_1234);
    wr(8'h04, 32'hffff_ffff);
    wr(8'h08, 32'hffff_ffff);
    rd_chk("src_ptr", 8'h04, 32'h0);
    rd_chk("dest_ptr", 8'h08, 32'h0);
    rd_chk("unmapped", 8'h1c, 32'h0);
    wr(8'h00, 32'h4);
    wr(8'h0c, 32'h2);
    wr(8'h18, 32'h1f);
  endtask
  task automatic t_dest();
    pulse(3'b010, 2);
    chk("dptr", 32'h2, {16'h0, dptr});
    rd_chk("status", 8'h14, 32'h02);
    pulse(3'b010, 2);
    chk("dptr", 32'h0, {16'h0, dptr});
    rd_chk("status", 8'h14, 32'h07);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h18, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
    wr(8'h18, 32'h4);
    chk("irq", 32'h1, {31'h0, irq});
    wr(8'h14, 32'h4);
    chk("irq", 32'h0, {31'h0, irq});
    rd_chk("status", 8'h14, 32'h03);
    wr(8'h14, 32'h1f);
  endtask
  task automatic t_src();
    wr(8'h0c, 32'h3);
    pulse(3'b100, 1);
    chk("sptr", 32'h1, {16'h0, sptr});
    rd_chk("status", 8'h14, 32'h08);
    pulse(3'b100, 2);
    rd_chk("src_ptr", 8'h04, 32'h0);
    rd_chk("status", 8'h14, 32'h18);
    wr(8'h14, 32'h1f);
  endtask
  task automatic t_pattern();
    pulse(3'b100, 1);
    pulse(3'b001, 1);
    chk("sptr", 32'h1, {16'h0, sptr});
    rd_chk("status", 8'h14, 32'h08);
    wr(8'h10, 32'h1);
    pulse(3'b101, 1);
    chk("sptr", 32'h0, {16'h0, sptr});
    rd_chk("status", 8'h14, 32'h09);
    wr(8'h14, 32'h1f);
    wr(8'h10, 32'h0);
  endtask
  task automatic t_full_span();
    wr(8'h00, 32'h0);
    pulse(3'b010, 65535);
    rd_chk("dest_ptr", 8'h08, 32'h0000_ffff);
    rd_chk("status", 8'h14, 32'h02);
    pulse(3'b010, 1);
    chk("dptr", 32'h0, {16'h0, dptr});
    rd_chk("status", 8'h14, 32'h07);
  endtask
  task automatic summarize();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_dest();
    t_src();
    t_pattern();
    t_full_span();
    summarize();
  end
endmodule
